// [afe_ctrl_bank.sv]
// afe control word interpreter and register bank with clock and sample dividers
//
// What this block does
// - top bit high marks a control word in program and mixed modes
// - top bit low: data word in mixed mode, ignored in program mode
// - write bit low at device address zero stores data field in register
// - read bit high at address zero returns register in data field, forwards word
// - nonzero device address is decremented and the word forwarded
// - register address field bits ten to eight picks the register
// - low eight bits carry write value or receive read value
// - serial-mode bit 0 selects program mode or data mode
// - serial-mode bits 1 to 3 enable mixed, digital and serial loop-back
// - serial-mode bits 6 to 4 hold cascade device count
// - serial-mode bit 7 set starts a software reset
// - clock-rate bits 1 and 0 select the sample rate
// - clock-rate bits 3 and 2 select the serial clock divider
// - clock-rate bits 6 to 4 select the master clock divider
// - clock-rate bit 7 enables control echo
// - power bit 0 global on, bits 1 to 5 power single blocks
// - power bit 6 enables reference output, bit 7 reserved zero
// - gain register: input gain, modulator reset, output gain, mute
// - dac timing register: advance, interpolator bypass, gain tap, test mode
// - analog tap register: coefficient, single-ended enable, invert, loop or mute
// - registers change on the falling serial clock edge
// - master divider codes 0 to 4 divide by 1 to 5, others by one
// - serial divider codes give divide by 8, 4, 2, 1; 8 default
// - sample codes give divide by 2048, 1024, 512, 256; 2048 default
`timescale 1ns/100ps
module afe_ctrl_bank import afe_pkg::*; (
	// clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RST_N,
	// serial port pins
	input  wire logic       SDI,
	input  wire logic       SDIFS,
	output logic            SCLK,
	output logic            SDO,
	output logic            SDOFS,
	// clocks and sample timing
	output logic            DIV_MASTER_CLK_TICK,
	output logic            SAMPLE_TICK,
	// received data words
	output logic [15:0]     DAC_DATA,
	output logic            DAC_STROBE,
	// control registers
	output logic [7:0]      SERIAL_MODE,
	output logic [7:0]      CLOCK_RATE,
	output logic [7:0]      POWER,
	output logic [7:0]      GAIN,
	output logic [7:0]      DAC_TIMING,
	output logic [7:0]      ANALOG_TAP,
	// effective block power after the global override
	output logic [4:0]      BLOCK_POWER
);

	//////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic                          sdi_s1;
		logic                          sdi_s2;
		logic                          fs_s1;
		logic                          fs_s2;
		logic                          sclk;
		logic [NUM_REGS-1:0][7:0]      regs;
		logic [WORD_BITS-1:0]          rx_word;
		logic [4:0]                    rx_cnt;
		logic                          rx_busy;
		logic [WORD_BITS-1:0]          tx_word;
		logic [4:0]                    tx_cnt;
		logic                          tx_busy;
		logic                          tx_pend;
		logic [WORD_BITS-1:0]          tx_next;
		logic                          sdo;
		logic                          sdofs;
		logic [15:0]                   dac_data;
		logic                          dac_strobe;
		logic [4:0]                    blk_pwr;
		logic                          dm_tick;
		logic                          smp_tick;
	} afe_st_t;

	afe_st_t st;
	afe_st_t next_st;

	logic [DIV_W-1:0] mcd_ratio;
	logic [DIV_W-1:0] scd_ratio;
	logic [DIV_W-1:0] sr_ratio;
	logic             dm_tick;
	logic             sc_tick;
	logic             sr_tick;

	//////////////////////////////////////////////////////////////////////////////
	// divider ratio selection from the clock-rate register

	always_comb begin
		case (st.regs[REG_CLOCK_RATE][CR_MCD_HI:CR_MCD_LO])
			3'h0:    mcd_ratio = MCD_DIV1;
			3'h1:    mcd_ratio = MCD_DIV2;
			3'h2:    mcd_ratio = MCD_DIV3;
			3'h3:    mcd_ratio = MCD_DIV4;
			3'h4:    mcd_ratio = MCD_DIV5;
			default: mcd_ratio = MCD_DIV1;
		endcase
		case (st.regs[REG_CLOCK_RATE][CR_SCD_HI:CR_SCD_LO])
			2'h0:    scd_ratio = SCD_DIV8;
			2'h1:    scd_ratio = SCD_DIV4;
			2'h2:    scd_ratio = SCD_DIV2;
			default: scd_ratio = SCD_DIV1;
		endcase
		case (st.regs[REG_CLOCK_RATE][CR_RATE_HI:CR_RATE_LO])
			2'h0:    sr_ratio = SR_DIV2048;
			2'h1:    sr_ratio = SR_DIV1024;
			2'h2:    sr_ratio = SR_DIV512;
			default: sr_ratio = SR_DIV256;
		endcase
	end

	afe_div #(.WIDTH(DIV_W)) u_mdiv (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.en    (1'b1),
		.ratio (mcd_ratio),
		.tick  (dm_tick)
	);

	afe_div #(.WIDTH(DIV_W)) u_sdiv (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.en    (dm_tick),
		.ratio (scd_ratio),
		.tick  (sc_tick)
	);

	afe_div #(.WIDTH(DIV_W)) u_rdiv (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.en    (dm_tick),
		.ratio (sr_ratio),
		.tick  (sr_tick)
	);

	//////////////////////////////////////////////////////////////////////////////
	// serial shifting and control word decode

	logic                 sclk_fall;
	logic                 sclk_rise;
	logic [WORD_BITS-1:0] word;
	logic [2:0]           dev_addr;
	logic [2:0]           reg_addr;
	logic                 mapped;
	logic                 op_data;
	logic                 mixed;

	always_comb begin
		next_st            = st;
		next_st.dac_strobe = 1'b0;
		next_st.dm_tick    = dm_tick;
		next_st.smp_tick   = sr_tick;

		// first stages feed only the second stages
		next_st.sdi_s1 = SDI;
		next_st.sdi_s2 = st.sdi_s1;
		next_st.fs_s1  = SDIFS;
		next_st.fs_s2  = st.fs_s1;

		sclk_fall = sc_tick && st.sclk;
		sclk_rise = sc_tick && !st.sclk;
		if (sc_tick) begin
			next_st.sclk = !st.sclk;
		end

		word     = {st.rx_word[WORD_BITS-2:0], st.sdi_s2};
		dev_addr = word[CW_DEV_HI:CW_DEV_LO];
		reg_addr = word[CW_REG_HI:CW_REG_LO];
		mapped   = (reg_addr < 3'(NUM_REGS));
		op_data  = st.regs[REG_SERIAL_MODE][SM_OP_MODE];
		mixed    = st.regs[REG_SERIAL_MODE][SM_MIXED];

		// receive on the falling edge; the frame sync marks the first bit
		if (sclk_fall) begin
			if (!st.rx_busy) begin
				if (st.fs_s2) begin
					next_st.rx_word = word;
					next_st.rx_cnt  = 5'h01;
					next_st.rx_busy = 1'b1;
				end
			end else if (st.rx_cnt != 5'(WORD_BITS - 1)) begin
				next_st.rx_word = word;
				next_st.rx_cnt  = st.rx_cnt + 5'h01;
			end else begin
				next_st.rx_word = word;
				next_st.rx_busy = 1'b0;
				if (op_data && !mixed) begin
					// plain data mode: every word is converter data
					next_st.dac_data   = word;
					next_st.dac_strobe = 1'b1;
				end else if (!word[CW_CTRL]) begin
					if (mixed) begin
						next_st.dac_data   = word;
						next_st.dac_strobe = 1'b1;
					end
				end else if (dev_addr != 3'h0) begin
					next_st.tx_next = word;
					next_st.tx_next[CW_DEV_HI:CW_DEV_LO] = dev_addr - 3'h1;
					next_st.tx_pend = 1'b1;
				end else if (word[CW_RW]) begin
					next_st.tx_next = word;
					next_st.tx_next[CW_DAT_HI:0] = mapped ? st.regs[reg_addr] : 8'h00;
					next_st.tx_pend = 1'b1;
				end else begin
					if (mapped) begin
						next_st.regs[reg_addr] = word[CW_DAT_HI:0];
					end
					if (reg_addr == REG_POWER) begin
						next_st.regs[REG_POWER][PW_RESERVED] = 1'b0;
					end
					// echo of addressed writes only when enabled
					if (st.regs[REG_CLOCK_RATE][CR_ECHO]) begin
						next_st.tx_next = word;
						next_st.tx_pend = 1'b1;
					end
					// software reset returns every register, itself included, to zero
					if (reg_addr == REG_SERIAL_MODE && word[SM_SW_RESET]) begin
						for (int i = 0; i < NUM_REGS; i++) begin
							next_st.regs[i] = REG_RESET;
						end
					end
				end
			end
		end

		// transmit on the rising edge so the far end samples on the falling one
		if (sclk_rise) begin
			next_st.sdofs = 1'b0;
			if (st.tx_busy) begin
				next_st.sdo     = st.tx_word[WORD_BITS-1];
				next_st.tx_word = {st.tx_word[WORD_BITS-2:0], 1'b0};
				if (st.tx_cnt == 5'(WORD_BITS - 1)) begin
					next_st.tx_busy = 1'b0;
				end else begin
					next_st.tx_cnt = st.tx_cnt + 5'h01;
				end
			end else if (st.tx_pend) begin
				next_st.sdofs   = 1'b1;
				next_st.sdo     = st.tx_next[WORD_BITS-1];
				next_st.tx_word = {st.tx_next[WORD_BITS-2:0], 1'b0};
				next_st.tx_cnt  = 5'h01;
				next_st.tx_busy = 1'b1;
				next_st.tx_pend = 1'b0;
			end else begin
				next_st.sdo = 1'b0;
			end
		end

		// global power-on overrides the single block enables
		next_st.blk_pwr = st.regs[REG_POWER][PW_BLK_HI:PW_BLK_LO]
			| {5{st.regs[REG_POWER][PW_GLOBAL]}};
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign SCLK        = st.sclk;
	assign SDO         = st.sdo;
	assign SDOFS       = st.sdofs;
	assign DIV_MASTER_CLK_TICK = st.dm_tick;
	assign SAMPLE_TICK = st.smp_tick;
	assign DAC_DATA    = st.dac_data;
	assign DAC_STROBE  = st.dac_strobe;
	assign SERIAL_MODE = st.regs[REG_SERIAL_MODE];
	assign CLOCK_RATE  = st.regs[REG_CLOCK_RATE];
	assign POWER       = st.regs[REG_POWER];
	assign GAIN        = st.regs[REG_GAIN];
	assign DAC_TIMING  = st.regs[REG_DAC_TIMING];
	assign ANALOG_TAP  = st.regs[REG_ANALOG_TAP];
	assign BLOCK_POWER = st.blk_pwr;

endmodule // afe_ctrl_bank

// [afe_pkg.sv]
// afe control word bank: field layout, register indices and divider ratios
package afe_pkg;

	// control word layout, sixteen bits, shifted msb first
	localparam int WORD_BITS = 16;
	localparam int CW_CTRL   = 15;
	localparam int CW_RW     = 14;
	localparam int CW_DEV_HI = 13;
	localparam int CW_DEV_LO = 11;
	localparam int CW_REG_HI = 10;
	localparam int CW_REG_LO = 8;
	localparam int CW_DAT_HI = 7;

	// register indices in the register address field
	localparam logic [2:0] REG_SERIAL_MODE = 3'h0;
	localparam logic [2:0] REG_CLOCK_RATE  = 3'h1;
	localparam logic [2:0] REG_POWER       = 3'h2;
	localparam logic [2:0] REG_GAIN        = 3'h3;
	localparam logic [2:0] REG_DAC_TIMING  = 3'h4;
	localparam logic [2:0] REG_ANALOG_TAP  = 3'h5;
	localparam int         NUM_REGS        = 6;
	localparam logic [7:0] REG_RESET       = 8'h00;

	// afe_serial_mode_ctrl
	localparam int SM_OP_MODE  = 0;
	localparam int SM_MIXED    = 1;
	localparam int SM_DLOOP    = 2;
	localparam int SM_SLOOP    = 3;
	localparam int SM_CASC_LO  = 4;
	localparam int SM_CASC_HI  = 6;
	localparam int SM_SW_RESET = 7;

	// afe_clock_rate_ctrl
	localparam int CR_RATE_LO = 0;
	localparam int CR_RATE_HI = 1;
	localparam int CR_SCD_LO  = 2;
	localparam int CR_SCD_HI  = 3;
	localparam int CR_MCD_LO  = 4;
	localparam int CR_MCD_HI  = 6;
	localparam int CR_ECHO    = 7;

	// afe_power_ctrl
	localparam int PW_GLOBAL   = 0;
	localparam int PW_BLK_LO   = 1;
	localparam int PW_BLK_HI   = 5;
	localparam int PW_REFOUT   = 6;
	localparam int PW_RESERVED = 7;

	// divider ratios, counted in half-periods of the master clock pin (one CLK_SYS cycle)
	localparam int DIV_W = 13;
	localparam logic [DIV_W-1:0] MCD_DIV1 = 13'h0001;
	localparam logic [DIV_W-1:0] MCD_DIV2 = 13'h0002;
	localparam logic [DIV_W-1:0] MCD_DIV3 = 13'h0003;
	localparam logic [DIV_W-1:0] MCD_DIV4 = 13'h0004;
	localparam logic [DIV_W-1:0] MCD_DIV5 = 13'h0005;
	// serial clock half-period in divided master clock half-periods
	localparam logic [DIV_W-1:0] SCD_DIV8 = 13'h0008;
	localparam logic [DIV_W-1:0] SCD_DIV4 = 13'h0004;
	localparam logic [DIV_W-1:0] SCD_DIV2 = 13'h0002;
	localparam logic [DIV_W-1:0] SCD_DIV1 = 13'h0001;
	// sample period in divided master clock half-periods (twice the period count)
	localparam logic [DIV_W-1:0] SR_DIV2048 = 13'h1000;
	localparam logic [DIV_W-1:0] SR_DIV1024 = 13'h0800;
	localparam logic [DIV_W-1:0] SR_DIV512  = 13'h0400;
	localparam logic [DIV_W-1:0] SR_DIV256  = 13'h0200;

endpackage

// [afe_div.sv]
// afe tick divider: one registered tick every ratio enabled cycles
`timescale 1ns/100ps
module afe_div import afe_pkg::*; #(
	parameter int WIDTH = DIV_W
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// count control
	input  wire logic             en,
	input  wire logic [WIDTH-1:0] ratio,
	// result
	output logic                  tick
);

	// the restart compare needs at least a two-bit count
	if (WIDTH < 2) begin : g_width_check
		$error("afe_div: WIDTH too small");
	end

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic             tick;
	} afe_div_st_t;

	afe_div_st_t st;
	afe_div_st_t next_st;

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (en) begin
			// a ratio that shrinks below the count restarts cleanly instead of wrapping
			if (st.cnt >= ratio - 1'b1) begin
				next_st.cnt  = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule // afe_div

// [afe_ctrl_bank_properties.sv]
// assertion checker for the afe control word bank
`timescale 1ns/100ps
module afe_ctrl_bank_props (
	// clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	// serial and timing outputs
	input wire logic        SCLK,
	input wire logic        SDOFS,
	input wire logic        DIV_MASTER_CLK_TICK,
	input wire logic        SAMPLE_TICK,
	input wire logic [15:0] DAC_DATA,
	input wire logic        DAC_STROBE,
	// registers
	input wire logic [7:0]  SERIAL_MODE,
	input wire logic [7:0]  CLOCK_RATE,
	input wire logic [7:0]  POWER,
	input wire logic [7:0]  GAIN,
	input wire logic [4:0]  BLOCK_POWER
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic [12:0] gap;
	logic        armed;
	logic [7:0]  pw_q;
	wire  [31:0] regs = {SERIAL_MODE, CLOCK_RATE, POWER, GAIN};
	// a rate change leaves the divider count running under the new ratio, so the gap after it is not judged
	always_ff @(posedge CLK_SYS) begin
		gap   <= (!RST_N || SAMPLE_TICK) ? 13'h0001 : gap + 13'h0001;
		armed <= (!RST_N || $changed(CLOCK_RATE)) ? 1'b0 : (armed | SAMPLE_TICK);
		pw_q  <= POWER;
	end
	////////////////////////////////////////////////////////////
	sclk_half_a: assert property (
		$rose(SCLK) && CLOCK_RATE[6:2] == 5'h00 |-> SCLK[*8] ##1 !SCLK)
		else $error("serial clock half period wrong");
	master_tick_a: assert property (
		$past(RST_N, 3) && CLOCK_RATE[6:4] == 3'h0 |-> DIV_MASTER_CLK_TICK)
		else $error("master clock tick missing at divide by one");
	sample_gap_a: assert property (
		SAMPLE_TICK && armed && !$changed(CLOCK_RATE) && CLOCK_RATE[6:4] == 3'h0
		|-> gap == (13'h1000 >> CLOCK_RATE[1:0])) else $error("sample period wrong");
	reg_change_a: assert property (
		$changed(regs) |-> !SCLK && ($past(SCLK) || $past(SCLK, 2)))
		else $error("register changed away from falling serial clock");
	dac_strobe_a: assert property (
		$changed(DAC_DATA) |-> DAC_STROBE ##1 !DAC_STROBE)
		else $error("data word update without single strobe");
	sdofs_len_a: assert property (
		$rose(SDOFS) && CLOCK_RATE[6:2] == 5'h00 |-> SDOFS[*8] ##1 SDOFS[*8] ##1 !SDOFS)
		else $error("output frame sync length wrong");
	power_rsvd_a: assert property (
		POWER[7] == 1'b0) else $error("reserved power bit set");
	block_power_a: assert property (
		BLOCK_POWER == (pw_q[5:1] | {5{pw_q[0]}})) else $error("block power wrong");
	sw_reset_a: assert property (
		SERIAL_MODE[7] == 1'b0) else $error("software reset bit read back set");
endmodule // afe_ctrl_bank_props

bind afe_ctrl_bank afe_ctrl_bank_props i_afe_ctrl_bank_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.SCLK(SCLK), .SDOFS(SDOFS), .DIV_MASTER_CLK_TICK(DIV_MASTER_CLK_TICK),
	.SAMPLE_TICK(SAMPLE_TICK),
	.DAC_DATA(DAC_DATA), .DAC_STROBE(DAC_STROBE), .SERIAL_MODE(SERIAL_MODE),
	.CLOCK_RATE(CLOCK_RATE), .POWER(POWER), .GAIN(GAIN), .BLOCK_POWER(BLOCK_POWER));

// [afe_dsp_port.sv]
// serial port model of the host processor: sends words and gathers replies
`timescale 1ns/100ps
module afe_dsp_port (
	// clock
	input  wire logic clk,
	// serial pins of the bank
	input  wire logic sclk,
	input  wire logic sdo,
	input  wire logic sdofs,
	output logic      sdi,
	output logic      sdifs
);
	logic        sclk_q  = 1'b0;
	logic [15:0] shift   = 16'h0;
	logic [15:0] rx_word = 16'h0;
	int          rx_bits = 16;
	int          rx_cnt  = 0;
	wire         rise    = sclk & ~sclk_q;
	wire         fall    = ~sclk & sclk_q;
	initial begin
		sdi   = 1'b0;
		sdifs = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// replies are taken at the fall, half a period after the bank moved them
	always @(posedge clk) begin
		sclk_q <= sclk;
		if (fall && (sdofs || rx_bits < 16)) begin
			shift = {shift[14:0], sdo};
			rx_bits = sdofs ? 1 : rx_bits + 1;
			if (rx_bits == 16) begin
				rx_word = shift;
				rx_cnt++;
			end
		end
	end
	// bits move just after the rise, far ahead of the synchroniser window
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= -1; i--) begin
			@(posedge clk iff rise);
			sdi   <= (i >= 0) ? w[i] : ~w[0];
			sdifs <= (i == 15);
		end
	endtask
endmodule // afe_dsp_port

// [test_afe_ctrl_bank.sv]
// testbench for the afe control word bank
`timescale 1ns/100ps
module test_afe_ctrl_bank;
	import afe_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        sdi, sdifs, sclk, sdo, sdofs;
	logic [15:0] dac_data;
	logic [7:0]  sm, cr, pw, gn, dt, at;
	logic [47:0] exp_regs = 48'h0;
	logic [31:0] seed     = 32'hf359b93e;
	logic [31:0] t;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles     = 0;
	wire  [47:0] regs_all   = {at, dt, gn, pw, cr, sm};

	afe_ctrl_bank i_afe_ctrl_bank (.CLK_SYS(clk_sys), .RST_N(rst_n), .SDI(sdi), .SDIFS(sdifs),
		.SCLK(sclk), .SDO(sdo), .SDOFS(sdofs), .DIV_MASTER_CLK_TICK(), .SAMPLE_TICK(),
		.DAC_DATA(dac_data), .DAC_STROBE(), .SERIAL_MODE(sm), .CLOCK_RATE(cr),
		.POWER(pw), .GAIN(gn), .DAC_TIMING(dt), .ANALOG_TAP(at), .BLOCK_POWER());
	afe_dsp_port i_afe_dsp_port (.clk(clk_sys), .sclk(sclk), .sdo(sdo), .sdofs(sdofs),
		.sdi(sdi), .sdifs(sdifs));

	initial forever #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] stored(input logic [2:0] r, input logic [7:0] d);
		return (r == REG_POWER) ? {1'b0, d[6:0]} : d;
	endfunction
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [15:0] w, input logic reply, input logic [15:0] exp_w);
		int n;
		n = i_afe_dsp_port.rx_cnt;
		i_afe_dsp_port.send(w);
		for (int i = 0; reply && i < 600 && i_afe_dsp_port.rx_cnt == n; i++) @(posedge clk_sys);
		if (reply && i_afe_dsp_port.rx_cnt == n) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time,
				i_afe_dsp_port.rx_cnt, n + 1);
		end
		if (reply) check({32'h0, i_afe_dsp_port.rx_word}, {32'h0, exp_w});
		check(regs_all, exp_regs);
	endtask
	task automatic wr(input logic [2:0] r, input logic [7:0] d);
		exp_regs[r*8 +: 8] = stored(r, d);
		xfer({5'h10, r, d}, 1'b0, 16'h0);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		exp_regs = 48'h0;
		@(posedge clk_sys);
		check(regs_all, 48'h0);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		logic [2:0] r;
		logic [7:0] d;
		do_reset();
		// data mode and unmapped addresses stay out of the random mix
		for (int k = 0; k < 18; k++) begin
			t = rnd();
			r = (k < 6) ? k[2:0] : 3'(t[31:16] % 6);
			// the host keeps the reserved power bit at zero
			d = stored(r, t[7:0] & ((r == REG_SERIAL_MODE) ? 8'h7e :
				(r == REG_CLOCK_RATE) ? 8'h03 : 8'hff));
			wr(r, d);
		end
		wr(REG_POWER, 8'h7f);
		$display("register writes done");
		for (int k = 0; k < 8; k++) begin
			d = (k < 6) ? exp_regs[k*8 +: 8] : 8'h00;
			xfer({5'h18, k[2:0], 8'h00}, 1'b1, {5'h18, k[2:0], d});
		end
		for (int k = 1; k < 8; k++) begin
			t = rnd();
			xfer({1'b1, t[14], k[2:0], t[10:0]}, 1'b1, {1'b1, t[14], k[2:0] - 3'h1, t[10:0]});
		end
		xfer({5'h10, 3'h6, 8'hff}, 1'b0, 16'h0);
		xfer({5'h10, 3'h7, 8'ha5}, 1'b0, 16'h0);
		$display("read and forward done");
		t = rnd();
		wr(REG_SERIAL_MODE, 8'h00);
		xfer({1'b0, t[14:0]}, 1'b0, 16'h0);
		check({32'h0, dac_data}, 48'h0);
		wr(REG_SERIAL_MODE, 8'h0e);
		xfer({1'b0, t[14:0]}, 1'b0, 16'h0);
		check({32'h0, dac_data}, {33'h0, t[14:0]});
		wr(REG_GAIN, 8'h3c);
		wr(REG_CLOCK_RATE, 8'h80);
		repeat (400) @(posedge clk_sys);
		exp_regs[31:24] = 8'h66;
		xfer(16'h8366, 1'b1, 16'h8366);
		wr(REG_CLOCK_RATE, 8'h00);
		repeat (400) @(posedge clk_sys);
		$display("mode and echo done");
		for (int k = 3; k >= 0; k--) begin
			wr(REG_CLOCK_RATE, 8'(k));
			repeat ((4096 >> k) * 2 + 64) @(posedge clk_sys);
		end
		exp_regs = 48'h0;
		xfer({5'h10, REG_SERIAL_MODE, 8'h80}, 1'b0, 16'h0);
		wr(REG_SERIAL_MODE, 8'h01);
		xfer(16'h835a, 1'b0, 16'h0);
		check({32'h0, dac_data}, 48'h835a);
		do_reset();
		$display("rates and resets done");
		close_out();
	end
endmodule // test_afe_ctrl_bank
